/* hdl/pid_control_loop.sv */
// Periodic PID control block with an AXI4-Lite register slave.
// Assumes source values arrive on aclk from upstream logic, no synchroniser.
//
// Summary of operation
// - Four response profiles: single, setpoint, on-over-target, on-below-target.
// - While enabled, run one calculation every loop period of milliseconds.
// - Single profile scales target and feedback each by its own range.
// - Single profile result is clamped between minus and plus full scale.
// - Setpoint profile forces and locks the target source to the constant.
// - Setpoint uses feedback range for the constant; result zero to full.
// - Over and below profiles give a result from zero to full scale.
// - Error with magnitude below the deadband is replaced by zero.
// - Sample period in seconds is loop period milliseconds times 0.001.
// - P gain is G; I gain G*Ki*T/Ti; D gain G*Kd*Td/T.
// - Integral time of zero gives integral gain zero, no division.
// - Error is target minus feedback, summed; result is P plus I plus D.
// - When the output selects this block, its result drives the output.
`timescale 1ns/1ps
`include "pid_consts.svh"
module pid_control_loop
    import pid_pkg::*;
(
    // Clock and reset
    input  wire logic               aclk,
    input  wire logic               aresetn,
    // AXI4-Lite write address
    input  wire logic [4:0]         s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    // AXI4-Lite read
    input  wire logic [4:0]         s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    // Target sources, entry 0 is the constant data list entry
    input  wire logic signed [15:0] target_value [16],
    input  wire logic signed [15:0] target_min   [16],
    input  wire logic signed [15:0] target_max   [16],
    // Feedback sources
    input  wire logic signed [15:0] feedback_value [16],
    input  wire logic signed [15:0] feedback_min   [16],
    input  wire logic signed [15:0] feedback_max   [16],
    // Output channel
    input  wire logic signed [15:0] other_command,
    output logic signed [15:0]      pid_result,
    output logic signed [15:0]      output_command,
    output logic                    result_strobe
);
    // Registers written by software
    logic        enable_reg, enable_next;
    logic [1:0]  profile_reg, profile_next;
    logic [3:0]  tsrc_reg, tsrc_next;
    logic [3:0]  fsrc_reg, fsrc_next;
    logic        outsel_reg, outsel_next;
    logic [15:0] period_reg, period_next;
    logic [15:0] deadband_reg, deadband_next;
    logic [15:0] gain_reg, gain_next;
    logic [15:0] ifactor_reg, ifactor_next;
    logic [15:0] itime_reg, itime_next;
    logic [15:0] dfactor_reg, dfactor_next;
    logic [15:0] dtime_reg, dtime_next;
    // Bus handshake state
    logic        aw_reg, aw_next, w_reg, w_next, bv_reg, bv_next, rv_reg, rv_next;
    logic [4:0]  awa_reg, awa_next;
    logic [31:0] wd_reg, wd_next, rd_reg, rd_next;
    logic [1:0]  br_reg, br_next, rr_reg, rr_next;
    logic        wr_fire;
    logic [31:0] rd_word;
    logic        rd_ok;
    logic [1:0]  prof_w;

    assign s_axi_awready = !aw_reg && !bv_reg;
    assign s_axi_wready  = !w_reg && !bv_reg;
    assign s_axi_arready = !rv_reg;
    assign s_axi_bvalid  = bv_reg;
    assign s_axi_bresp   = br_reg;
    assign s_axi_rvalid  = rv_reg;
    assign s_axi_rdata   = rd_reg;
    assign s_axi_rresp   = rr_reg;
    assign wr_fire = (aw_reg || (s_axi_awvalid && s_axi_awready))
                     && (w_reg || (s_axi_wvalid && s_axi_wready)) && !bv_reg;

    // Read mux; status half of the control word shows the PID result
    logic signed [31:0] esum_reg;
    loop_state_e        st_reg;
    always_comb begin
        rd_ok = 1'b1;
        case (s_axi_araddr)
            `ADDR_CTRL:     rd_word = {pid_result, 3'b000, outsel_reg, fsrc_reg,
                                       tsrc_reg, 1'b0, profile_reg, enable_reg};
            `ADDR_PERIOD:   rd_word = {16'h0000, period_reg};
            `ADDR_DEADBAND: rd_word = {16'h0000, deadband_reg};
            `ADDR_GAIN:     rd_word = {16'h0000, gain_reg};
            `ADDR_IFACTOR:  rd_word = {16'h0000, ifactor_reg};
            `ADDR_ITIME:    rd_word = {16'h0000, itime_reg};
            `ADDR_DFACTOR:  rd_word = {16'h0000, dfactor_reg};
            `ADDR_DTIME:    rd_word = {16'h0000, dtime_reg};
            default: begin
                rd_word = 32'h0000_0000;
                rd_ok   = 1'b0;
            end
        endcase
    end

    // Bus channels and register writes; writes take effect when both halves are in
    always_comb begin
        aw_next = aw_reg; w_next = w_reg; awa_next = awa_reg; wd_next = wd_reg;
        bv_next = bv_reg; br_next = br_reg; rv_next = rv_reg; rd_next = rd_reg;
        rr_next = rr_reg;
        enable_next = enable_reg; profile_next = profile_reg; tsrc_next = tsrc_reg;
        fsrc_next = fsrc_reg; outsel_next = outsel_reg; period_next = period_reg;
        deadband_next = deadband_reg; gain_next = gain_reg; ifactor_next = ifactor_reg;
        itime_next = itime_reg; dfactor_next = dfactor_reg; dtime_next = dtime_reg;
        prof_w = wd_next[`CTRL_PROFILE_LSB +: 2];
        if (s_axi_awvalid && s_axi_awready) begin
            aw_next = 1'b1;
            awa_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_next = 1'b1;
            wd_next = s_axi_wdata;
        end
        prof_w = wd_next[`CTRL_PROFILE_LSB +: 2];
        if (bv_reg && s_axi_bready) begin
            bv_next = 1'b0;
        end
        if (wr_fire) begin
            aw_next = 1'b0;
            w_next = 1'b0;
            bv_next = 1'b1;
            br_next = 2'b00;
            case (awa_next)
                `ADDR_CTRL: begin
                    enable_next  = wd_next[`CTRL_ENABLE_BIT];
                    profile_next = prof_w;
                    // Setpoint profile pins the target to the constant entry
                    tsrc_next = (profile_e'(prof_w) == PROF_SETPT) ? `TSRC_CONSTANT
                                : wd_next[`CTRL_TSRC_LSB +: 4];
                    fsrc_next   = wd_next[`CTRL_FSRC_LSB +: 4];
                    outsel_next = wd_next[`CTRL_OUTSEL_BIT];
                end
                `ADDR_PERIOD:   period_next   = wd_next[15:0];
                `ADDR_DEADBAND: deadband_next = wd_next[15:0];
                `ADDR_GAIN:     gain_next     = wd_next[15:0];
                `ADDR_IFACTOR:  ifactor_next  = wd_next[15:0];
                `ADDR_ITIME:    itime_next    = wd_next[15:0];
                `ADDR_DFACTOR:  dfactor_next  = wd_next[15:0];
                `ADDR_DTIME:    dtime_next    = wd_next[15:0];
                default:        br_next       = 2'b10;
            endcase
        end
        if (rv_reg && s_axi_rready) begin
            rv_next = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rv_next = 1'b1;
            rd_next = rd_word;
            rr_next = rd_ok ? 2'b00 : 2'b10;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_reg <= 1'b0; w_reg <= 1'b0; awa_reg <= 5'h00; wd_reg <= 32'h0000_0000;
            bv_reg <= 1'b0; br_reg <= 2'b00; rv_reg <= 1'b0; rd_reg <= 32'h0000_0000;
            rr_reg <= 2'b00;
            enable_reg <= 1'b0; profile_reg <= 2'b00; tsrc_reg <= 4'h0; fsrc_reg <= 4'h0;
            outsel_reg <= 1'b0; period_reg <= `PERIOD_RESET; deadband_reg <= 16'h0000;
            gain_reg <= `GAIN_RESET; ifactor_reg <= 16'h0000; itime_reg <= 16'h0000;
            dfactor_reg <= 16'h0000; dtime_reg <= 16'h0000;
        end else begin
            aw_reg <= aw_next; w_reg <= w_next; awa_reg <= awa_next; wd_reg <= wd_next;
            bv_reg <= bv_next; br_reg <= br_next; rv_reg <= rv_next; rd_reg <= rd_next;
            rr_reg <= rr_next;
            enable_reg <= enable_next; profile_reg <= profile_next; tsrc_reg <= tsrc_next;
            fsrc_reg <= fsrc_next; outsel_reg <= outsel_next; period_reg <= period_next;
            deadband_reg <= deadband_next; gain_reg <= gain_next;
            ifactor_reg <= ifactor_next; itime_reg <= itime_next;
            dfactor_reg <= dfactor_next; dtime_reg <= dtime_next;
        end
    end

    // Millisecond tick and loop period count
    logic        tick;
    logic [15:0] ms_reg, ms_next;
    logic        period_hit;
    ms_tick u_tick (
        .aclk    (aclk),
        .aresetn (aresetn),
        .run     (enable_reg),
        .tick    (tick)
    );
    assign period_hit = tick && (ms_reg + 16'd1 >= period_reg);

    // Normalisation of both inputs
    profile_e           prof;
    logic signed [15:0] tgt_pct, fb_pct;
    logic signed [15:0] t_min, t_max;
    assign prof  = profile_e'(profile_reg);
    // Setpoint bounds the constant by the feedback range
    assign t_min = (prof == PROF_SETPT) ? feedback_min[fsrc_reg] : target_min[tsrc_reg];
    assign t_max = (prof == PROF_SETPT) ? feedback_max[fsrc_reg] : target_max[tsrc_reg];
    pct_scale u_tgt (
        .value   (target_value[tsrc_reg]),
        .src_min (t_min),
        .src_max (t_max),
        .clamp   (prof == PROF_SETPT),
        .pct     (tgt_pct)
    );
    pct_scale u_fb (
        .value   (feedback_value[fsrc_reg]),
        .src_min (feedback_min[fsrc_reg]),
        .src_max (feedback_max[fsrc_reg]),
        .clamp   (1'b0),
        .pct     (fb_pct)
    );

    // Loop datapath state
    loop_state_e        st_next;
    logic signed [31:0] esum_next;
    logic signed [16:0] err_reg, err_next, eprev_reg, eprev_next;
    logic signed [47:0] ig_reg, ig_next, dg_reg, dg_next;
    logic signed [63:0] acc_reg, acc_next;
    logic signed [15:0] res_reg, res_next;
    logic               stb_reg, stb_next, en_d_reg;
    logic signed [16:0] err_raw;
    logic [16:0]        err_abs;
    logic signed [63:0] pterm, iterm, dterm;
    logic signed [63:0] lo_lim;

    // Sequencer: gains, error, terms, sum; one pass per loop period
    always_comb begin
        st_next = st_reg; ms_next = ms_reg; esum_next = esum_reg; err_next = err_reg;
        eprev_next = eprev_reg; ig_next = ig_reg; dg_next = dg_reg; acc_next = acc_reg;
        res_next = res_reg; stb_next = 1'b0;
        err_raw = 17'(tgt_pct) - 17'(fb_pct);
        err_abs = err_raw[16] ? 17'(-err_raw) : 17'(err_raw);
        // P term scaled back by 256, I and D terms by 65536, for Q8.8 factors; T = period / 1000 seconds
        pterm = 64'(err_reg) * 64'(signed'({1'b0, gain_reg})) >>> 8;
        iterm = 64'(esum_reg) * 64'(ig_reg) >>> 16;
        dterm = (64'(err_reg) - 64'(eprev_reg)) * 64'(dg_reg) >>> 16;
        lo_lim = (prof == PROF_SINGLE) ? 64'(`PCT_NEG_FULL) : 64'sd0;
        if (tick) begin
            ms_next = period_hit ? 16'd0 : ms_reg + 16'd1;
        end
        case (st_reg)
            ST_IDLE: begin
                if (period_hit) st_next = ST_GAINS;
            end
            ST_GAINS: begin
                // Integral gain in Q16.16: G*Ki*period/(1000*Ti); Ti of zero gives zero
                ig_next = (itime_reg == 16'h0000) ? 48'sd0
                    : 48'(64'(gain_reg) * 64'(ifactor_reg) * 64'(period_reg)
                          / (64'(`MS_TO_S_RECIP) * 64'(itime_reg)));
                dg_next = (period_reg == 16'h0000) ? 48'sd0
                    : 48'(64'(gain_reg) * 64'(dfactor_reg) * 64'(dtime_reg)
                          * 64'(`MS_TO_S_RECIP) / 64'(period_reg));
                st_next = ST_NORM;
            end
            ST_NORM: st_next = ST_ERR;
            ST_ERR: begin
                // Small errors are zeroed so the output can settle
                err_next = (err_abs < 17'(deadband_reg)) ? 17'sd0 : err_raw;
                esum_next = esum_reg + 32'(((err_abs < 17'(deadband_reg)) ? 17'sd0
                                             : err_raw));
                st_next = ST_TERMS;
            end
            ST_TERMS: begin
                acc_next = pterm + iterm + dterm;
                st_next = ST_SUM;
            end
            ST_SUM: begin
                // Over and below profiles clip at zero and full scale
                if (acc_reg > 64'(`PCT_FULL)) res_next = `PCT_FULL;
                else if (acc_reg < lo_lim)   res_next = 16'(lo_lim);
                else                         res_next = acc_reg[15:0];
                eprev_next = err_reg;
                stb_next = 1'b1;
                st_next = ST_IDLE;
            end
            default: st_next = ST_IDLE;
        endcase
        if (!enable_reg) begin
            st_next = ST_IDLE;
            ms_next = 16'd0;
        end
        if (enable_reg && !en_d_reg) begin
            esum_next = 32'sd0;
            eprev_next = 17'sd0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= ST_IDLE; ms_reg <= 16'd0; esum_reg <= 32'sd0;
            err_reg <= 17'sd0; eprev_reg <= 17'sd0; ig_reg <= 48'sd0; dg_reg <= 48'sd0;
            acc_reg <= 64'sd0; res_reg <= 16'sd0; stb_reg <= 1'b0; en_d_reg <= 1'b0;
        end else begin
            st_reg <= st_next; ms_reg <= ms_next; esum_reg <= esum_next;
            err_reg <= err_next; eprev_reg <= eprev_next; ig_reg <= ig_next;
            dg_reg <= dg_next; acc_reg <= acc_next; res_reg <= res_next;
            stb_reg <= stb_next; en_d_reg <= enable_reg;
        end
    end

    // Output channel picks this block's result when selected
    logic signed [15:0] out_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_reg <= 16'sd0;
        end else begin
            out_reg <= outsel_reg ? res_next : other_command;
        end
    end
    assign pid_result     = res_reg;
    assign output_command = out_reg;
    assign result_strobe  = stb_reg;
endmodule // pid_control_loop

/* hdl/pid_consts.svh */
// Timing counts, fixed-point layout and register map for the PID loop block.
// Assumes inclusion by every design file that needs it; the package does not include it.
`ifndef PID_CONSTS_SVH
`define PID_CONSTS_SVH

// Clock and millisecond tick
`define CLK_PERIOD_NS      8
`define TICK_PERIOD_NS     1000000
`define TICK_CYCLES        (`TICK_PERIOD_NS / `CLK_PERIOD_NS)

// Fixed point: percentages are signed Q8.8 (100% = 25600)
`define PCT_FULL           16'sh6400
`define PCT_NEG_FULL       16'sh9C00
`define MS_TO_S_RECIP      1000

// Register byte addresses
`define ADDR_CTRL          5'h00
`define ADDR_PERIOD        5'h04
`define ADDR_DEADBAND      5'h08
`define ADDR_GAIN          5'h0C
`define ADDR_IFACTOR       5'h10
`define ADDR_ITIME         5'h14
`define ADDR_DFACTOR       5'h18
`define ADDR_DTIME         5'h1C

// Control register fields
`define CTRL_ENABLE_BIT    0
`define CTRL_PROFILE_LSB   1
`define CTRL_TSRC_LSB      4
`define CTRL_FSRC_LSB      8
`define CTRL_OUTSEL_BIT    12

// Reset values and the constant target source entry
`define PERIOD_RESET       16'h000A
`define GAIN_RESET         16'h0100
`define TSRC_CONSTANT      4'h0

`endif

/* hdl/pid_pkg.sv */
// Types shared by the PID loop block.
// Assumes pid_consts.svh carries the numeric constants.
package pid_pkg;
    typedef enum logic [1:0] {
        PROF_SINGLE  = 2'b00,
        PROF_SETPT   = 2'b01,
        PROF_OVER    = 2'b10,
        PROF_BELOW   = 2'b11
    } profile_e;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_NORM  = 3'b011,
        ST_ERR   = 3'b010,
        ST_TERMS = 3'b110,
        ST_SUM   = 3'b100,
        ST_GAINS = 3'b001
    } loop_state_e;
endpackage

/* hdl/pct_scale.sv */
// Converts a raw source value to a signed Q8.8 percentage of its range.
// Assumes min below max; a flat range yields zero. Combinational.
`timescale 1ns/1ps
`include "pid_consts.svh"
module pct_scale (
    // Source value and range
    input  wire logic signed [15:0] value,
    input  wire logic signed [15:0] src_min,
    input  wire logic signed [15:0] src_max,
    input  wire logic               clamp,
    // Percentage result
    output logic signed [15:0]      pct
);
    logic signed [16:0] span;
    logic signed [16:0] offs;
    logic signed [33:0] prod;
    logic signed [33:0] quot;

    // Bounding by the range keeps a constant target inside the feedback span
    always_comb begin
        span = 17'(src_max) - 17'(src_min);
        offs = 17'(value) - 17'(src_min);
        if (clamp && offs < 0) begin
            offs = '0;
        end else if (clamp && offs > span) begin
            offs = span;
        end
        prod = 34'(offs) * 34'(`PCT_FULL);
        quot = (span == 0) ? '0 : prod / 34'(span);
        if (quot > 34'(`PCT_FULL)) begin
            pct = `PCT_FULL;
        end else if (quot < 34'(`PCT_NEG_FULL)) begin
            pct = `PCT_NEG_FULL;
        end else begin
            pct = quot[15:0];
        end
    end
endmodule // pct_scale

/* hdl/ms_tick.sv */
// Divider producing a one-cycle pulse once per millisecond.
// Assumes a 125 MHz aclk; restarts whenever run is low.
`timescale 1ns/1ps
`include "pid_consts.svh"
module ms_tick (
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Control
    input  wire logic run,
    // Tick
    output logic      tick
);
    logic [16:0] cnt_reg;
    logic [16:0] cnt_next;

    // Count down the cycles of one millisecond
    always_comb begin
        cnt_next = cnt_reg;
        if (!run || cnt_reg == 17'd0) begin
            cnt_next = 17'(`TICK_CYCLES - 1);
        end else begin
            cnt_next = cnt_reg - 17'd1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg <= 17'(`TICK_CYCLES - 1);
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign tick = run && (cnt_reg == 17'd0);
endmodule // ms_tick

/* test/pid_control_loop_props.sv */
// Checker for the PID loop block: bus handshakes, result timing and range.
// Assumes it is bound onto pid_control_loop and sees only its ports.
`timescale 1ns/1ps
module pid_control_loop_props (
    // Clock and reset
    input wire logic               aclk,
    input wire logic               aresetn,
    // Register bus
    input wire logic               s_axi_awvalid,
    input wire logic               s_axi_awready,
    input wire logic               s_axi_wvalid,
    input wire logic               s_axi_wready,
    input wire logic [1:0]         s_axi_bresp,
    input wire logic               s_axi_bvalid,
    input wire logic               s_axi_bready,
    input wire logic               s_axi_arvalid,
    input wire logic               s_axi_arready,
    input wire logic [31:0]        s_axi_rdata,
    input wire logic               s_axi_rvalid,
    input wire logic               s_axi_rready,
    // Loop result
    input wire logic signed [15:0] pid_result,
    input wire logic               result_strobe
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Bus answers come one cycle after the request and stand until taken
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> s_axi_bvalid) else $error("write response late");
    a_write_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");

    // A pass runs once per period, so strobes are far apart
    a_strobe_gap: assert property (
        result_strobe |=> !result_strobe [*8]) else $error("strobe too close");
    // Result never leaves the widest documented span
    a_result_span: assert property (
        pid_result >= 16'sh9C00 && pid_result <= 16'sh6400) else $error("result out of span");
    // Result only moves together with its strobe
    a_result_moment: assert property (
        $changed(pid_result) |-> result_strobe) else $error("result moved without strobe");
endmodule // pid_control_loop_props

bind pid_control_loop pid_control_loop_props u_props (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .pid_result, .result_strobe);

/* test/pid_sources.sv */
// Model of the upstream source blocks feeding the PID loop block.
// Assumes the bench chooses which target and feedback entry carry real data.
`timescale 1ns/1ps
module pid_sources (
    // Clock
    input  wire logic               aclk,
    // Chosen entries and their value, minimum, maximum
    input  wire logic [3:0]         tsel,
    input  wire logic [3:0]         fsel,
    input  wire logic signed [15:0] tset [3],
    input  wire logic signed [15:0] fset [3],
    // Source outputs
    output logic signed [15:0]      target_value [16],
    output logic signed [15:0]      target_min [16],
    output logic signed [15:0]      target_max [16],
    output logic signed [15:0]      feedback_value [16],
    output logic signed [15:0]      feedback_min [16],
    output logic signed [15:0]      feedback_max [16]
);
    logic [15:0] churn_reg = 16'h0000;

    // Entries nobody chose churn every cycle, so a wrong pick cannot pass
    always @(posedge aclk) churn_reg <= churn_reg + 16'h3B5D;

    // Each chosen entry carries its own range, units may differ
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            target_value[i]   = (i == tsel) ? tset[0] : churn_reg ^ 16'(i);
            target_min[i]     = (i == tsel) ? tset[1] : churn_reg;
            target_max[i]     = (i == tsel) ? tset[2] : ~churn_reg;
            feedback_value[i] = (i == fsel) ? fset[0] : churn_reg + 16'(i);
            feedback_min[i]   = (i == fsel) ? fset[1] : ~churn_reg;
            feedback_max[i]   = (i == fsel) ? fset[2] : churn_reg;
        end
    end
endmodule // pid_sources

/* test/tb_pid_control_loop.sv */
// Self-checking bench for the PID loop block: registers, output pick, one loop pass.
// Assumes the checker binds itself; the loop pass costs about one millisecond.
`timescale 1ns/1ps
module tb_pid_control_loop;
    logic               aclk = 1'h0, aresetn = 1'h0;
    logic [4:0]         awaddr = 5'h00, araddr = 5'h00;
    logic [31:0]        wdata = 32'h0, rdata, val, w, exp;
    logic               awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic               arvalid = 1'h0, rready = 1'h0;
    logic               awready, wready, bvalid, arready, rvalid, strobe;
    logic [1:0]         bresp, rresp;
    logic signed [15:0] tv [16], tn [16], tx [16], fv [16], fn [16], fx [16];
    logic signed [15:0] tset [3] = '{16'sh0000, 16'sh0000, 16'sh0001};
    logic signed [15:0] fset [3] = '{16'sh0000, 16'sh0000, 16'sh0001};
    logic [3:0]         tsel = 4'h0, fsel = 4'h0;
    logic signed [15:0] other = 16'sh0000, result, command;
    int                 mismatches = 0, samples_checked = 0, n;

    // 125 MHz clock
    always #4 aclk = ~aclk;

    pid_control_loop dut_u (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .target_value(tv), .target_min(tn), .target_max(tx), .feedback_value(fv),
        .feedback_min(fn), .feedback_max(fx), .other_command(other), .pid_result(result),
        .output_command(command), .result_strobe(strobe));
    pid_sources src_u (.aclk, .tsel, .fsel, .tset, .fset, .target_value(tv),
        .target_min(tn), .target_max(tx), .feedback_value(fv), .feedback_min(fn),
        .feedback_max(fx));

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
        samples_checked++;
        if (got !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, e, got);
        end
    endtask

    task automatic end_sim;
        $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Write: address and data offered together, each dropped when taken
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            k++;
        end while (!bvalid && k < 200);
        bready <= 1'h0;
        if (!bvalid) begin mismatches++; end_sim(); end
        chk("bresp", 32'h0, {30'h0, bresp});
    endtask

    task automatic rd(input logic [4:0] a, output logic [31:0] d);
        int k;
        k = 0;
        @(posedge aclk);
        araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
            k++;
        end while (!rvalid && k < 200);
        rready <= 1'h0;
        d = rdata;
        if (!rvalid) begin mismatches++; end_sim(); end
        chk("rresp", 32'h0, {30'h0, rresp});
    endtask

    // Percentage of a source range in Q8.8, 100% being 25600
    function automatic logic [15:0] pct(input int v, input int lo, input int hi);
        return 16'((v - lo) * 25600 / (hi - lo));
    endfunction

    // Main sequence
    initial begin
        void'($urandom(3));
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        rd(5'h04, val); chk("period", 32'h0000000A, val);
        rd(5'h0C, val); chk("gain", 32'h00000100, val);
        rd(5'h00, val); chk("ctrl", 32'h00000000, val);
        // Random words: low half kept, upper half reads zero
        for (int a = 8; a < 32; a += 4) begin
            w = $urandom;
            wr(5'(a), w);
            rd(5'(a), val);
            chk("reg", {16'h0, w[15:0]}, val);
        end
        // Every profile; setpoint locks the target pick to the constant entry
        for (int p = 0; p < 4; p++) begin
            wr(5'h00, 32'h50 | (p << 1));
            rd(5'h00, val);
            chk("ctrl", (p == 1) ? 32'(p << 1) : 32'h50 | (p << 1), val);
        end
        // Output not picking the block follows the other command
        wr(5'h00, 32'h0);
        repeat (4) begin
            @(posedge aclk);
            other <= 16'($urandom);
            repeat (3) @(posedge aclk);
            chk("command", {16'h0, other}, {16'h0, command});
        end
        // One pass: 75% target, 25% feedback, P only, Ti zero despite random Ki
        tsel <= 4'h3; fsel <= 4'h7;
        tset <= '{16'sh004B, 16'sh0000, 16'sh0064};
        fset <= '{16'sh0019, 16'sh0000, 16'sh0064};
        wr(5'h04, 32'h1); wr(5'h08, 32'h100); wr(5'h0C, 32'h100);
        wr(5'h14, 32'h0); wr(5'h18, 32'h0); wr(5'h1C, 32'h0);
        wr(5'h00, 32'h1731);
        exp = {16'h0, pct(75, 0, 100) - pct(25, 0, 100)};
        for (n = 0; n < 130000 && strobe !== 1'h1; n++) @(posedge aclk);
        chk("strobe", 32'h1, {31'h0, strobe});
        chk("result", exp, {16'h0, result});
        @(posedge aclk);
        chk("command", exp, {16'h0, command});
        end_sim();
    end
endmodule // tb_pid_control_loop
